/* dv/wk_regs_assertions.sv */
`timescale 1ns/10ps
`include "wk_defs.vh"

// Port-level timing checks of the wake status bank.
module wk_regs_assertions (
    // Clock and reset.
    input wire CLK,
    input wire RSTN,
    // Register port.
    input wire [15:0] ADDR,
    input wire WR,
    input wire RD,
    input wire [15:0] RDATA,
    // Frame strobes and interrupt pins.
    input wire RX_SOF,
    input wire RX_EOF,
    input wire POLARITY_INT,
    input wire SHARED_INT,
    input wire IRQ
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RSTN);

    // A second status read with no frame event landing under the read before it.
    sequence s_stat_rd;
        RD && ADDR == `WK_OFS_STATUS;
    endsequence
    sequence s_quiet_rd;
        s_stat_rd ##0 (!$past(RX_EOF, 2) && !$past(RX_SOF, 2));
    endsequence
    // Shared pin high that the polarity copy cannot explain.
    sequence s_wake;
        SHARED_INT && !$past(POLARITY_INT);
    endsequence

    AST_RDATA_IDLE: assert property (!$past(RD) |-> RDATA == 16'h0000)
        else $error("read data not zero outside a read");
    AST_STAT_RSV: assert property ($past(RD) && $past(ADDR) ==
        `WK_OFS_STATUS |-> (RDATA & 16'hEF1C) == 16'h0000)
        else $error("reserved status bits not zero");
    AST_CFG_RSV: assert property ($past(RD) && $past(ADDR) ==
        `WK_OFS_CONFIG |-> (RDATA & 16'hCF5C) == 16'h0000)
        else $error("unused config bits not zero");
    AST_SHARED_CAUSE: assert property (s_wake |-> $past(RX_EOF, 2))
        else $error("wake pulse on shared pin without a frame");
    AST_SHARED_PULSE: assert property (s_wake |=>
        !(SHARED_INT && !$past(POLARITY_INT)))
        else $error("wake pulse on shared pin too long");
    AST_IRQ_CAUSE: assert property ($rose(IRQ) |-> $past(RX_SOF, 2) ||
        $past(RX_EOF, 2) || $past(WR) || $past(WR, 2))
        else $error("interrupt rose without a cause");
    AST_IRQ_STICKY: assert property ($fell(IRQ) |-> $past(WR) ||
        $past(WR, 2))
        else $error("interrupt fell without a write");
    AST_CLR_ON_RD: assert property (s_stat_rd ##1 s_quiet_rd |=>
        RDATA[7:0] == 8'h00)
        else $error("status flags survived a read");
endmodule // wk_regs_assertions

bind wk_regs wk_regs_assertions wk_regs_assertions_inst (.CLK(CLK),
    .RSTN(RSTN), .ADDR(ADDR), .WR(WR), .RD(RD), .RDATA(RDATA),
    .RX_SOF(RX_SOF), .RX_EOF(RX_EOF), .POLARITY_INT(POLARITY_INT),
    .SHARED_INT(SHARED_INT), .IRQ(IRQ));

/* dv/wk_regs_tb.sv */
`timescale 1ns/10ps
`include "wk_defs.vh"
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin error_cnt++; \
    $display("BAD t=%0t got=%h exp=%h", $time, a, e); end end

module wk_regs_tb;
    typedef struct packed {
        logic [15:0] cfg;
        logic [7:0] sfd;
        logic [3:0] f;
        logic [7:0] exp;
    } wk_row_t;
    // Config, delimiter, {crc ok, magic, pattern, password ok}, flags.
    localparam wk_row_t ROWS [11] = '{'{16'h1081, 8'hD5, 4'hD, 8'h01},
        '{16'h1082, 8'hD5, 4'hB, 8'h02}, '{16'h1083, 8'hD5, 4'h7, 8'h40},
        '{16'h0083, 8'hD5, 4'h5, 8'h01}, '{16'h1081, 8'h55, 4'hD, 8'h80},
        '{16'h3081, 8'h5D, 4'hD, 8'h01}, '{16'h3081, 8'hD5, 4'hD, 8'h80},
        '{16'h10A1, 8'hD5, 4'hC, 8'h20}, '{16'h10A1, 8'hD5, 4'hD, 8'h01},
        '{16'h0003, 8'hD5, 4'hD, 8'h00}, '{16'h1081, 8'hD5, 4'hC, 8'h01}};
    localparam logic [15:0] MV [6] = '{16'h5566, 16'h3344, 16'h1122,
        16'hB2A1, 16'hD4C3, 16'hF6E5};
    logic clk, rstn, wen, ren, pol;
    logic [15:0] addr, wdata, q;
    wire [15:0] rdata;
    wire [7:0] sfd;
    wire [47:0] dest, pwd;
    wire sof, eof, crc, mag, pv, pat, shared, irq;
    int error_cnt, n_checks;

    wk_regs wk_regs_inst (.CLK(clk), .RSTN(rstn), .ADDR(addr),
        .WDATA(wdata), .WR(wen), .RD(ren), .RDATA(rdata), .RX_SOF(sof),
        .RX_SFD(sfd), .RX_EOF(eof), .RX_CRC_OK(crc), .RX_DEST(dest),
        .RX_MAGIC(mag), .RX_PWD(pwd), .RX_PWD_VALID(pv), .RX_PATTERN(pat),
        .POLARITY_INT(pol), .SHARED_INT(shared), .IRQ(irq));
    wk_rx_node wk_rx_node_inst (.clk(clk), .rx_sof(sof), .rx_sfd(sfd),
        .rx_eof(eof), .rx_crc_ok(crc), .rx_dest(dest), .rx_magic(mag),
        .rx_pwd(pwd), .rx_pwd_valid(pv), .rx_pattern(pat));

    // Free-running 25 MHz clock.
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // Write strobe for one cycle; the idle cycle keeps strobes apart.
    task automatic wr(input [15:0] a, input [15:0] d);
        addr <= a;
        wdata <= d;
        wen <= 1'b1;
        @(posedge clk);
        wen <= 1'b0;
        @(posedge clk);
    endtask

    // Read data stand only in the cycle after the strobe.
    task automatic rd(input [15:0] a, output [15:0] d);
        addr <= a;
        ren <= 1'b1;
        @(posedge clk);
        ren <= 1'b0;
        #1 d = rdata;
        @(posedge clk);
    endtask

    task test_done;
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // The run needs under 300 cycles; this allows over fifteen times that.
    initial begin
        #200000;
        error_cnt++;
        test_done();
    end

    initial begin
        {rstn, wen, ren, pol, addr, wdata} = '0;
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        for (int i = 0; i < 9; i++) begin
            rd(16'(16'h04A0 + i), q);
            `CHK(q, i == 0 ? 16'h1000 : 16'h0000)
        end
        wr(16'h04A8, 16'hFFFF);
        rd(16'h04A8, q);
        `CHK(q, 16'h0000)
        for (int i = 0; i < 6; i++) begin
            wr(16'(16'h04A2 + i), MV[i]);
            rd(16'(16'h04A2 + i), q);
            `CHK(q, MV[i])
        end
        $display("test reset and match registers ended");
        wr(`WK_OFS_CONFIG, 16'h1081);
        rd(`WK_OFS_STATUS, q);
        `CHK(q, 16'h1000)
        pol <= 1'b1;
        repeat (3) @(posedge clk);
        #1 `CHK(shared, 1'b0)
        wr(`WK_OFS_STATUS, 16'h0000);
        #1 `CHK(shared, 1'b1)
        pol <= 1'b0;
        wr(`WK_OFS_STATUS, 16'h1000);
        wr(`WK_OFS_IRQ_MASK, 16'h00E3);
        wk_rx_node_inst.send(8'hD5, 4'hD);
        // The wake pulse shows on the shared pin in the same cycle as the flag.
        @(posedge clk);
        #1 `CHK(shared, 1'b1)
        @(posedge clk);
        #1 `CHK(shared, 1'b0)
        // Two status reads back to back: flags, then nothing left.
        addr <= `WK_OFS_STATUS;
        ren <= 1'b1;
        @(posedge clk);
        #1 `CHK(rdata, 16'h1001)
        @(posedge clk);
        ren <= 1'b0;
        #1 `CHK(rdata[7:0], 8'h00)
        wr(`WK_OFS_IRQ_STAT, 16'h00FF);
        $display("test interrupt source ended");
        for (int r = 0; r < 11; r++) begin
            wr(`WK_OFS_CONFIG, ROWS[r].cfg);
            wk_rx_node_inst.send(ROWS[r].sfd, ROWS[r].f);
            repeat (3) @(posedge clk);
            #1 `CHK(irq, ROWS[r].exp != 8'h00)
            rd(`WK_OFS_STATUS, q);
            `CHK(q[7:0], ROWS[r].exp)
            rd(`WK_OFS_STATUS, q);
            `CHK(q[7:0], 8'h00)
            wr(`WK_OFS_IRQ_STAT, 16'h00FF);
            #1 `CHK(irq, 1'b0)
        end
        $display("test frame table ended");
        // A read whose strobe meets the landing event must not lose it.
        wk_rx_node_inst.send(8'hD5, 4'hD);
        rd(`WK_OFS_STATUS, q);
        `CHK(q[7:0], 8'h00)
        rd(`WK_OFS_STATUS, q);
        `CHK(q[7:0], 8'h01)
        $display("test same-cycle event ended");
        rstn <= 1'b0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        rd(`WK_OFS_CONFIG, q);
        `CHK(q, 16'h1000)
        test_done();
    end
endmodule // wk_regs_tb

/* dv/wk_rx_node.sv */
`timescale 1ns/10ps

// Remote node: hands one received frame over as delimiter and end pulses.
module wk_rx_node (
    // Clock.
    input wire clk,
    // Frame observations.
    output reg rx_sof,
    output reg [7:0] rx_sfd,
    output reg rx_eof,
    output reg rx_crc_ok,
    output reg [47:0] rx_dest,
    output reg rx_magic,
    output reg [47:0] rx_pwd,
    output reg rx_pwd_valid,
    output reg rx_pattern
);
    localparam [47:0] DEST = 48'h665544332211;
    localparam [47:0] PWD = 48'hF6E5D4C3B2A1;

    // Idle lines start low.
    initial begin
        {rx_sof, rx_sfd, rx_eof, rx_crc_ok, rx_dest, rx_magic} = '0;
        {rx_pwd, rx_pwd_valid, rx_pattern} = '0;
    end

    // Between frames the qualifiers flip so stale values never look valid.
    task automatic send(input [7:0] sfd, input [3:0] f);
        @(posedge clk);
        rx_sof <= 1'b1;
        rx_sfd <= sfd;
        @(posedge clk);
        rx_sof <= 1'b0;
        rx_sfd <= ~sfd;
        repeat (2) @(posedge clk);
        rx_eof <= 1'b1;
        {rx_crc_ok, rx_magic, rx_pattern, rx_pwd_valid} <= {f[3:1], 1'b1};
        rx_dest <= DEST;
        rx_pwd <= f[0] ? PWD : ~PWD;
        @(posedge clk);
        rx_eof <= 1'b0;
        {rx_crc_ok, rx_magic, rx_pattern, rx_pwd_valid} <= ~{f[3:1], 1'b1};
        rx_dest <= ~DEST;
        rx_pwd <= ~rx_pwd;
    endtask
endmodule // wk_rx_node

/* logic/wk_defs.vh */
`ifndef WK_DEFS_VH
`define WK_DEFS_VH

// Register offsets on the management port.
`define WK_OFS_CONFIG 16'h04A0
`define WK_OFS_STATUS 16'h04A1
`define WK_OFS_DA_HI 16'h04A2
`define WK_OFS_DA_MID 16'h04A3
`define WK_OFS_DA_LO 16'h04A4
`define WK_OFS_PWD_LO 16'h04A5
`define WK_OFS_PWD_MID 16'h04A6
`define WK_OFS_PWD_HI 16'h04A7
`define WK_OFS_IRQ_STAT 16'h04B0
`define WK_OFS_IRQ_MASK 16'h04B1

// Field positions in the wake configuration register.
`define WK_CFG_SFD_SEL 13
`define WK_CFG_CRC_GATE 12
`define WK_CFG_WAKE_EN 7
`define WK_CFG_SECURE_EN 5
`define WK_CFG_PAT_EN 1
`define WK_CFG_MAGIC_EN 0

// Field positions in the wake status register.
`define WK_ST_INT_SRC 12
`define WK_ST_SFD_ERR 7
`define WK_ST_BAD_CRC 6
`define WK_ST_HACK 5
`define WK_ST_PATTERN 1
`define WK_ST_MAGIC 0

// Writable bits of the configuration register and sticky status bits.
`define WK_CFG_WMASK 16'h30A3
`define WK_ST_FLAGS 16'h00E3

// Reset values.
`define WK_CFG_RESET 16'h1000
`define WK_ST_RESET 16'h0000
`define WK_MATCH_RESET 16'h0000

// Start-of-frame delimiter bytes.
`define WK_SFD_ALT 8'h5D
`define WK_SFD_STD 8'hD5

`endif

/* logic/wk_frame_eval.v */
`timescale 1ns/10ps
`include "wk_defs.vh"

// Judges each received frame against the configured wake settings.
module wk_frame_eval (
    // Clock and reset.
    input wire clk,
    input wire rst_n,
    // Configuration from the register bank.
    input wire [15:0] cfg,
    input wire [47:0] dest_addr,
    input wire [47:0] password,
    // Frame observations from the receive path.
    input wire rx_sof,
    input wire [7:0] rx_sfd,
    input wire rx_eof,
    input wire rx_crc_ok,
    input wire [47:0] rx_dest,
    input wire rx_magic,
    input wire [47:0] rx_pwd,
    input wire rx_pwd_valid,
    input wire rx_pattern,
    // One-cycle event pulses, status bit layout.
    output reg [15:0] events
);

    reg frame_ok;
    reg [7:0] sfd_want;
    reg crc_bad;
    reg gated;
    reg magic_ok;
    reg pwd_fail;
    reg [15:0] next_events;
    reg next_frame_ok;

    // Evaluate the delimiter at frame start and the body at frame end.
    always @* begin
        sfd_want = cfg[`WK_CFG_SFD_SEL] ? `WK_SFD_ALT : `WK_SFD_STD;
        next_events = 16'h0000;
        next_frame_ok = frame_ok;
        crc_bad = ~rx_crc_ok;
        gated = cfg[`WK_CFG_CRC_GATE] & crc_bad;
        magic_ok = rx_magic & cfg[`WK_CFG_MAGIC_EN] & (rx_dest == dest_addr)
            & ~gated;
        pwd_fail = magic_ok & cfg[`WK_CFG_SECURE_EN]
            & (~rx_pwd_valid | (rx_pwd != password));
        if (rx_sof) begin
            next_frame_ok = (rx_sfd == sfd_want);
            if (cfg[`WK_CFG_WAKE_EN] && rx_sfd != sfd_want) begin
                next_events[`WK_ST_SFD_ERR] = 1'b1;
            end
        end else if (rx_eof) begin
            next_frame_ok = 1'b0;
            // A frame lacking its delimiter never reaches the matchers.
            if (cfg[`WK_CFG_WAKE_EN] && frame_ok) begin
                next_events[`WK_ST_BAD_CRC] = gated;
                next_events[`WK_ST_HACK] = pwd_fail;
                next_events[`WK_ST_MAGIC] = magic_ok & ~pwd_fail;
                next_events[`WK_ST_PATTERN] = rx_pattern
                    & cfg[`WK_CFG_PAT_EN] & ~gated;
            end
        end
    end

    // Events are pulses; the frame flag lives from start to end only.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            events <= 16'h0000;
            frame_ok <= 1'b0;
        end else begin
            events <= next_events;
            frame_ok <= next_frame_ok;
        end
    end

endmodule // wk_frame_eval

/* logic/wk_regs.v */
// Decided for this implementation: strobed register access.
`timescale 1ns/10ps
`include "wk_defs.vh"

module wk_regs (
    // Clock and reset.
    input wire CLK,
    input wire RSTN,
    // Register port.
    input wire [15:0] ADDR,
    input wire [15:0] WDATA,
    input wire WR,
    input wire RD,
    output reg [15:0] RDATA,
    // Receive path observations.
    input wire RX_SOF,
    input wire [7:0] RX_SFD,
    input wire RX_EOF,
    input wire RX_CRC_OK,
    input wire [47:0] RX_DEST,
    input wire RX_MAGIC,
    input wire [47:0] RX_PWD,
    input wire RX_PWD_VALID,
    input wire RX_PATTERN,
    // Shared interrupt source and outputs.
    input wire POLARITY_INT,
    output reg SHARED_INT,
    output reg IRQ
);

    reg [15:0] wake_config;
    reg [15:0] wake_status;
    reg [15:0] wake_dest_addr_hi;
    reg [15:0] wake_dest_addr_mid;
    reg [15:0] wake_dest_addr_lo;
    reg [15:0] wake_password_lo;
    reg [15:0] wake_password_mid;
    reg [15:0] wake_password_hi;
    reg [15:0] irq_status;
    reg [15:0] irq_mask;
    reg [15:0] next_rdata;
    reg [15:0] next_status;
    reg [15:0] next_irq_status;
    wire [15:0] events;
    wire [47:0] dest_addr;
    wire [47:0] password;
    wire wake_event;
    wire wr_config;
    wire wr_status;
    wire rd_status;

    // True when a strobe hits the given offset.
    function hit;
        input strobe;
        input [15:0] addr;
        input [15:0] ofs;
        begin
            hit = strobe & (addr == ofs);
        end
    endfunction

    // Sticky flag update where a new event beats the clear.
    function [15:0] sticky;
        input [15:0] cur;
        input [15:0] clr;
        input [15:0] ev;
        begin
            sticky = ((cur & ~clr) | ev) & `WK_ST_FLAGS;
        end
    endfunction

    // Byte n of the destination address is dest_addr[8n+7:8n].
    assign dest_addr = {wake_dest_addr_hi[7:0], wake_dest_addr_hi[15:8],
        wake_dest_addr_mid[7:0], wake_dest_addr_mid[15:8],
        wake_dest_addr_lo[7:0], wake_dest_addr_lo[15:8]};
    // Byte n of the password is password[8n+7:8n].
    assign password = {wake_password_hi, wake_password_mid,
        wake_password_lo};

    assign wr_config = hit(WR, ADDR, `WK_OFS_CONFIG);
    assign wr_status = hit(WR, ADDR, `WK_OFS_STATUS);
    assign rd_status = hit(RD, ADDR, `WK_OFS_STATUS);
    assign wake_event = events[`WK_ST_MAGIC] | events[`WK_ST_PATTERN];

    // Frame judge; its pulses arrive one cycle after the frame strobes.
    wk_frame_eval u_eval (
        .clk(CLK),
        .rst_n(RSTN),
        .cfg(wake_config),
        .dest_addr(dest_addr),
        .password(password),
        .rx_sof(RX_SOF),
        .rx_sfd(RX_SFD),
        .rx_eof(RX_EOF),
        .rx_crc_ok(RX_CRC_OK),
        .rx_dest(RX_DEST),
        .rx_magic(RX_MAGIC),
        .rx_pwd(RX_PWD),
        .rx_pwd_valid(RX_PWD_VALID),
        .rx_pattern(RX_PATTERN),
        .events(events)
    );

    // Status update: a read clears every flag in one step, events still win.
    always @* begin
        next_status = wake_status;
        next_status[15:0] = sticky(wake_status,
            rd_status ? `WK_ST_FLAGS : 16'h0000, events);
        next_status[`WK_ST_INT_SRC] = wake_status[`WK_ST_INT_SRC];
        if (wr_status) begin
            next_status[`WK_ST_INT_SRC] = WDATA[`WK_ST_INT_SRC];
        end
        // Enabling detection forces the source over any same-cycle write.
        if (wr_config && WDATA[`WK_CFG_WAKE_EN]
            && !wake_config[`WK_CFG_WAKE_EN]) begin
            next_status[`WK_ST_INT_SRC] = 1'b1;
        end
    end

    // Interrupt status is write-one-to-clear; a new event beats the clear.
    always @* begin
        next_irq_status = sticky(irq_status,
            hit(WR, ADDR, `WK_OFS_IRQ_STAT) ? WDATA : 16'h0000, events);
    end

    // Read multiplexer; reserved bits and unmapped offsets read zero.
    always @* begin
        next_rdata = 16'h0000;
        if (!RD) begin
            next_rdata = 16'h0000;
        end else if (ADDR == `WK_OFS_CONFIG) begin
            next_rdata = wake_config;
        end else if (ADDR == `WK_OFS_STATUS) begin
            next_rdata = wake_status;
        end else if (ADDR == `WK_OFS_DA_HI) begin
            next_rdata = wake_dest_addr_hi;
        end else if (ADDR == `WK_OFS_DA_MID) begin
            next_rdata = wake_dest_addr_mid;
        end else if (ADDR == `WK_OFS_DA_LO) begin
            next_rdata = wake_dest_addr_lo;
        end else if (ADDR == `WK_OFS_PWD_LO) begin
            next_rdata = wake_password_lo;
        end else if (ADDR == `WK_OFS_PWD_MID) begin
            next_rdata = wake_password_mid;
        end else if (ADDR == `WK_OFS_PWD_HI) begin
            next_rdata = wake_password_hi;
        end else if (ADDR == `WK_OFS_IRQ_STAT) begin
            next_rdata = irq_status;
        end else if (ADDR == `WK_OFS_IRQ_MASK) begin
            next_rdata = irq_mask;
        end
    end

    // Configuration and match registers written by software.
    always @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            wake_config <= `WK_CFG_RESET;
            wake_dest_addr_hi <= `WK_MATCH_RESET;
            wake_dest_addr_mid <= `WK_MATCH_RESET;
            wake_dest_addr_lo <= `WK_MATCH_RESET;
            wake_password_lo <= `WK_MATCH_RESET;
            wake_password_mid <= `WK_MATCH_RESET;
            wake_password_hi <= `WK_MATCH_RESET;
            irq_mask <= 16'h0000;
        end else if (WR) begin
            if (ADDR == `WK_OFS_CONFIG) begin
                wake_config <= WDATA & `WK_CFG_WMASK;
            end else if (ADDR == `WK_OFS_DA_HI) begin
                wake_dest_addr_hi <= WDATA;
            end else if (ADDR == `WK_OFS_DA_MID) begin
                wake_dest_addr_mid <= WDATA;
            end else if (ADDR == `WK_OFS_DA_LO) begin
                wake_dest_addr_lo <= WDATA;
            end else if (ADDR == `WK_OFS_PWD_LO) begin
                wake_password_lo <= WDATA;
            end else if (ADDR == `WK_OFS_PWD_MID) begin
                wake_password_mid <= WDATA;
            end else if (ADDR == `WK_OFS_PWD_HI) begin
                wake_password_hi <= WDATA;
            end else if (ADDR == `WK_OFS_IRQ_MASK) begin
                irq_mask <= WDATA & `WK_ST_FLAGS;
            end
        end
    end

    // Status, interrupt state and registered outputs.
    always @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            wake_status <= `WK_ST_RESET;
            irq_status <= 16'h0000;
            RDATA <= 16'h0000;
            SHARED_INT <= 1'b0;
            IRQ <= 1'b0;
        end else begin
            wake_status <= next_status;
            irq_status <= next_irq_status;
            RDATA <= next_rdata;
            // The shared bit follows the selected source one cycle later.
            SHARED_INT <= wake_status[`WK_ST_INT_SRC] ? wake_event
                : POLARITY_INT;
            IRQ <= |(next_irq_status & irq_mask);
        end
    end

endmodule // wk_regs
